// File: hw/spls_cfg.svh
// Purpose: constants for the serializer power-down and lock sequencer
// Assumes: counts are in parallel clock cycles
// Notes:   included by bare name
`ifndef SPLS_CFG_SVH
`define SPLS_CFG_SVH
`define SPLS_LOCK_CYCLES  32'h4001
`define SPLS_RNG_3_5      2'h0
`define SPLS_RNG_5_10     2'h1
`define SPLS_RNG_10_20    2'h2
`define SPLS_RNG_20_35    2'h3
`define SPLS_BIT_RATIO    8'h14
// range limits in MHz, low and high
`define SPLS_MHZ_3        8'h03
`define SPLS_MHZ_5        8'h05
`define SPLS_MHZ_10       8'h0a
`define SPLS_MHZ_20       8'h14
`define SPLS_MHZ_35       8'h23
`endif

// File: hw/spls_pkg.sv
// Purpose: types for the serializer power-down and lock sequencer
// Assumes: nothing beyond the cfg header
// Notes:   no imports are used anywhere
package spls_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        SPLS_OFF  = 2'h0,
        SPLS_LOCK = 2'h1,
        SPLS_RUN  = 2'h2
    } spls_state_t;
    // decoded range facts
    typedef struct packed {
        logic [7:0] min_mhz;
        logic [7:0] max_mhz;
        logic [7:0] bit_ratio;
    } spls_range_t;
    // output driver controls
    typedef struct packed {
        logic term_on;
        logic drive_en;
        logic pll_run;
    } spls_drv_t;
endpackage

// File: hw/spls_range_dec.sv
// Purpose: decodes the two-bit clock range select
// Assumes: select is static in operation
// Notes:   purely combinational
`timescale 1ns/10ps
`include "spls_cfg.svh"
module spls_range_dec (
    // select in
    input  wire logic [1:0]          sel,
    // decoded range
    output spls_pkg::spls_range_t    range
);
    // table lookup, every code legal
    always_comb begin
        range.bit_ratio = `SPLS_BIT_RATIO;
        unique case (sel)
            `SPLS_RNG_3_5: begin
                range.min_mhz = `SPLS_MHZ_3;
                range.max_mhz = `SPLS_MHZ_5;
            end
            `SPLS_RNG_5_10: begin
                range.min_mhz = `SPLS_MHZ_5;
                range.max_mhz = `SPLS_MHZ_10;
            end
            `SPLS_RNG_10_20: begin
                range.min_mhz = `SPLS_MHZ_10;
                range.max_mhz = `SPLS_MHZ_20;
            end
            `SPLS_RNG_20_35: begin
                range.min_mhz = `SPLS_MHZ_20;
                range.max_mhz = `SPLS_MHZ_35;
            end
        endcase
    end
endmodule

// File: hw/spls_seq.sv
// Purpose: power-down and lock sequencing of a serial video driver
// Assumes: clk stands for the parallel input clock
// Notes:   inputs synchronous to clk
`timescale 1ns/10ps
`include "spls_cfg.svh"
module spls_seq #(
    parameter int unsigned LOCK_CYCLES = `SPLS_LOCK_CYCLES
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // control pins
    input  wire logic                 power_down_n,
    input  wire logic                 input_buffer_supply,
    input  wire logic                 freq_range_select_hi,
    input  wire logic                 freq_range_select_lo,
    // driver controls
    output spls_pkg::spls_drv_t       drv,
    output logic                      locked,
    output logic                      inputs_enabled,
    // decoded range
    output spls_pkg::spls_range_t     range
);
    localparam int CW = $clog2(LOCK_CYCLES + 1); // counter width, holds the full count
    localparam int AW = CW + 1;                  // checker age width, room past the count

    spls_pkg::spls_state_t  state_r;      // sequencer state
    spls_pkg::spls_state_t  state_nxt;
    logic [CW-1:0]          cnt_r;        // lock counter
    logic [CW-1:0]          cnt_nxt;
    spls_pkg::spls_drv_t    drv_r;        // registered driver controls
    spls_pkg::spls_drv_t    drv_nxt;
    logic                   inen_r;       // inputs enabled flag
    logic                   inen_nxt;
    spls_pkg::spls_range_t  range_r;      // registered range
    spls_pkg::spls_range_t  range_dec;    // decoder output
    logic                   pd_int;       // internal power-down
    logic [AW-1:0]          age_r;        // edges since release, checks only
    logic [AW-1:0]          age_nxt;

    // range table
    spls_range_dec u_dec (
        .sel   ({freq_range_select_hi, freq_range_select_lo}),
        .range (range_dec)
    );

    // supply loss overrides the pin
    assign pd_int = !power_down_n || !input_buffer_supply;

    // next state and counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        drv_nxt   = '0;
        inen_nxt  = input_buffer_supply;
        if (pd_int) begin
            // driver controls all off, count cleared; inputs follow the supply only
            state_nxt = spls_pkg::SPLS_OFF;
            cnt_nxt   = '0;
        end else begin
            unique case (state_r)
                spls_pkg::SPLS_OFF: begin
                    state_nxt = spls_pkg::SPLS_LOCK;
                    cnt_nxt   = CW'(1);
                    drv_nxt   = '{term_on: 1'b1, drive_en: 1'b0, pll_run: 1'b1};
                end
                spls_pkg::SPLS_LOCK: begin
                    // termination in, driver held off
                    drv_nxt = '{term_on: 1'b1, drive_en: 1'b0, pll_run: 1'b1};
                    if (cnt_r == CW'(LOCK_CYCLES)) begin
                        state_nxt = spls_pkg::SPLS_RUN;
                        drv_nxt.drive_en = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + CW'(1);
                    end
                end
                spls_pkg::SPLS_RUN: begin
                    drv_nxt = '{term_on: 1'b1, drive_en: 1'b1, pll_run: 1'b1};
                end
                default: begin
                    // illegal code recovers to off
                    state_nxt = spls_pkg::SPLS_OFF;
                    cnt_nxt   = '0;
                end
            endcase
        end
    end

    // register everything
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= spls_pkg::SPLS_OFF;
            cnt_r   <= '0;
            drv_r   <= '0;
            inen_r  <= 1'b0;
            range_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            drv_r   <= drv_nxt;
            inen_r  <= inen_nxt;
            range_r <= range_dec;
        end
    end

    // independent edge count since release, read only by the checks below;
    // it saturates so a long run cannot wrap it back onto the lock figure
    always_comb begin
        age_nxt = age_r;
        if (pd_int) begin
            // power-down restarts the measurement
            age_nxt = '0;
        end else if (age_r != '1) begin
            age_nxt = age_r + AW'(1);
        end
    end

    // register the age count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            age_r <= '0;
        end else begin
            age_r <= age_nxt;
        end
    end

    // outputs straight from the registers
    assign drv            = drv_r;
    assign locked         = drv_r.drive_en;
    assign inputs_enabled = inen_r;
    assign range          = range_r;

    // lock phase: termination on, driver off
    sequence s_release;
        $fell(pd_int);
    endsequence
    property p_release_term;
        @(posedge clk) disable iff (rst) s_release |=> drv_r.term_on && !drv_r.drive_en;
    endproperty
    a_release_term: assert property (p_release_term) else $error("termination not on at release");

    property p_pd_off;
        @(posedge clk) disable iff (rst) pd_int |=> drv_r == '0;
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("driver not off in power-down");

    property p_supply_loss;
        @(posedge clk) disable iff (rst) !input_buffer_supply |=> !inen_r && !drv_r.pll_run;
    endproperty
    a_supply_loss: assert property (p_supply_loss) else $error("supply loss did not power down");

    property p_count_clear;
        @(posedge clk) disable iff (rst) pd_int |=> cnt_r == '0 && state_r == spls_pkg::SPLS_OFF;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("counter not cleared");

    property p_no_drive_early;
        @(posedge clk) disable iff (rst) drv_r.drive_en |-> cnt_r == CW'(LOCK_CYCLES);
    endproperty
    a_no_drive_early: assert property (p_no_drive_early) else $error("driving before lock");

    property p_lock_time;
        @(posedge clk) disable iff (rst)
            (state_r == spls_pkg::SPLS_LOCK && cnt_r == CW'(LOCK_CYCLES) && !pd_int) |=> locked;
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock not reached at count end");

    property p_lock_step;
        @(posedge clk) disable iff (rst)
            (state_r == spls_pkg::SPLS_LOCK && cnt_r != CW'(LOCK_CYCLES) && !pd_int) |=> cnt_r == $past(cnt_r) + CW'(1);
    endproperty
    a_lock_step: assert property (p_lock_step) else $error("lock counter did not step");

    property p_range;
        @(posedge clk) disable iff (rst)
            {freq_range_select_hi, freq_range_select_lo} == `SPLS_RNG_20_35 |=>
            range_r.max_mhz == `SPLS_MHZ_35 && range_r.min_mhz == `SPLS_MHZ_20;
    endproperty
    a_range: assert property (p_range) else $error("range decode wrong");

    // lowest band
    property p_range_3_5;
        @(posedge clk) disable iff (rst)
            {freq_range_select_hi, freq_range_select_lo} == `SPLS_RNG_3_5 |=>
            range_r.max_mhz == `SPLS_MHZ_5 && range_r.min_mhz == `SPLS_MHZ_3;
    endproperty
    a_range_3_5: assert property (p_range_3_5) else $error("low band decode wrong");

    // second band
    property p_range_5_10;
        @(posedge clk) disable iff (rst)
            {freq_range_select_hi, freq_range_select_lo} == `SPLS_RNG_5_10 |=>
            range_r.max_mhz == `SPLS_MHZ_10 && range_r.min_mhz == `SPLS_MHZ_5;
    endproperty
    a_range_5_10: assert property (p_range_5_10) else $error("second band decode wrong");

    // third band
    property p_range_10_20;
        @(posedge clk) disable iff (rst)
            {freq_range_select_hi, freq_range_select_lo} == `SPLS_RNG_10_20 |=>
            range_r.max_mhz == `SPLS_MHZ_20 && range_r.min_mhz == `SPLS_MHZ_10;
    endproperty
    a_range_10_20: assert property (p_range_10_20) else $error("third band decode wrong");

    // serial rate ratio is the same in every band
    property p_bit_ratio;
        @(posedge clk) disable iff (rst) 1'b1 |=> range_r.bit_ratio == `SPLS_BIT_RATIO;
    endproperty
    a_bit_ratio: assert property (p_bit_ratio) else $error("bit ratio wrong");

    // inputs come back with the supply
    property p_inputs_on;
        @(posedge clk) disable iff (rst) input_buffer_supply |=> inen_r;
    endproperty
    a_inputs_on: assert property (p_inputs_on) else $error("inputs not enabled with supply");

    // release also starts the pll
    property p_release_pll;
        @(posedge clk) disable iff (rst) s_release |=> drv_r.pll_run;
    endproperty
    a_release_pll: assert property (p_release_pll) else $error("pll not started at release");

    // no drive anywhere in the lock phase, termination kept in
    property p_lock_quiet;
        @(posedge clk) disable iff (rst) state_r == spls_pkg::SPLS_LOCK |-> !drv_r.drive_en && drv_r.term_on;
    endproperty
    a_lock_quiet: assert property (p_lock_quiet) else $error("driven during lock");

    // once running, the output stays driven until power-down
    property p_run_hold;
        @(posedge clk) disable iff (rst) (state_r == spls_pkg::SPLS_RUN && !pd_int) |=> locked && drv_r.term_on;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("drive lost while running");

    // drive starts one edge after the full count, measured from release
    sequence s_lock_end;
        $rose(drv_r.drive_en);
    endsequence
    property p_lock_age;
        @(posedge clk) disable iff (rst) s_lock_end |-> age_r == AW'(LOCK_CYCLES) + AW'(1);
    endproperty
    a_lock_age: assert property (p_lock_age) else $error("lock time from release wrong");
endmodule

// File: verif/spls_rx_model.sv
// Purpose: receiver side of the serial link, watching the driver controls
// Assumes: link is usable only while driven and terminated
// Notes:   behavioural, no serial decoding
`timescale 1ns/10ps
module spls_rx_model (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // driver controls seen at the cable
    input  spls_pkg::spls_drv_t drv,
    // receiver status
    output logic                link_up_r
);
    // lock only counts once the driver really sends, never on termination alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_up_r <= 1'b0;
        end else begin
            link_up_r <= drv.drive_en & drv.term_on;
        end
    end
endmodule

// File: verif/tb_serializer_powerdown_lock_seq.sv
// Purpose: self-checking bench of the power-down and lock sequencer
// Assumes: lock count shortened to 8 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`include "spls_cfg.svh"
module tb_serializer_powerdown_lock_seq;
    localparam int unsigned LOCKN = 32'h8; // shortened lock count
    logic                  clk = 1'b0;     // parallel clock
    logic                  rst = 1'b1;     // async reset
    logic                  pdn = 1'b0;     // power-down, active low
    logic                  sup = 1'b1;     // input supply present
    logic [1:0]            sel = 2'h0;     // range select
    spls_pkg::spls_drv_t   drv;            // driver controls
    logic                  locked;         // lock flag
    logic                  inp_en;         // inputs enabled
    spls_pkg::spls_range_t range;          // decoded range
    logic                  link;           // receiver status
    integer                seed = 11629;   // fixed seed
    int                    n_mismatch = 0; // mismatches
    int                    checks_done = 0; // comparisons
    // 50 MHz clock
    always #10 clk = ~clk;
    spls_seq #(.LOCK_CYCLES(LOCKN)) u_dut (.clk(clk), .rst(rst), .power_down_n(pdn),
        .input_buffer_supply(sup), .freq_range_select_hi(sel[1]), .freq_range_select_lo(sel[0]),
        .drv(drv), .locked(locked), .inputs_enabled(inp_en), .range(range));
    spls_rx_model u_rx (.clk(clk), .rst(rst), .drv(drv), .link_up_r(link));
    // expected range facts per select code
    function automatic spls_pkg::spls_range_t exp_range(input logic [1:0] s);
        spls_pkg::spls_range_t r;
        r.bit_ratio = `SPLS_BIT_RATIO;
        case (s)
            2'h0: {r.min_mhz, r.max_mhz} = {`SPLS_MHZ_3, `SPLS_MHZ_5};
            2'h1: {r.min_mhz, r.max_mhz} = {`SPLS_MHZ_5, `SPLS_MHZ_10};
            2'h2: {r.min_mhz, r.max_mhz} = {`SPLS_MHZ_10, `SPLS_MHZ_20};
            default: {r.min_mhz, r.max_mhz} = {`SPLS_MHZ_20, `SPLS_MHZ_35};
        endcase
        return r;
    endfunction
    // one comparison
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // wait edges, then step off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // verdict
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // release and follow the full lock count; supply and clock held steady
    task automatic lock_run;
        pdn = 1'b1;
        step(1);
        check("start", 24'({drv.term_on, drv.pll_run, drv.drive_en}), 24'h6);
        step(LOCKN - 1);
        check("early", 24'({locked, drv.drive_en, link}), 24'h0);
        step(1);
        check("lock", 24'({locked, drv.drive_en}), 24'h3);
    endtask
    // hang guard
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
    // main sequence
    initial begin
        step(10);
        rst = 1'b0;
        step(2);
        check("pd", 24'(drv), 24'h0);
        for (int i = 0; i < 4; i++) begin
            sel = 2'(i);
            step(1);
            check("range", range, exp_range(2'(i)));
        end
        $display("test range done");
        lock_run();
        step(1);
        check("link", 24'(link), 24'h1);
        $display("test lock done");
        // abort mid-lock, then a full count again
        pdn = 1'b0;
        step(1);
        check("drop", 24'(drv), 24'h0);
        pdn = 1'b1;
        step(4);
        pdn = 1'b0;
        step(1);
        check("abort", 24'({locked, drv}), 24'h0);
        lock_run();
        $display("test abort done");
        // supply loss forces power-down
        sup = 1'b0;
        step(1);
        check("supply", 24'({inp_en, drv}), 24'h0);
        sup = 1'b1;
        lock_run();
        check("inputs", 24'(inp_en), 24'h1);
        $display("test supply done");
        // random range codes and power-down lengths; clock held at 50 MHz, above every band
        for (int i = 0; i < 20; i++) begin
            sel = 2'($random(seed));
            pdn = 1'b0;
            step(1 + int'($unsigned($random(seed)) % 4));
            check("rpd", 24'(drv), 24'h0);
            check("rrange", range, exp_range(sel));
            lock_run();
        end
        $display("test random done");
        // async reset in the middle of a run, then a clean full count
        rst = 1'b1;
        step(1);
        check("rst", 24'({locked, inp_en, drv, link}), 24'h0);
        rst = 1'b0;
        lock_run();
        $display("test reset done");
        finish_test();
    end
endmodule
